//--- rtl/rxq_pkg.sv
// Purpose: Shared constants and types for the receive data qualification block
// Assumes: 125 MHz system clock, all pin inputs asynchronous to it
// Notes:   Rate divider counts are in system clock cycles per filter tick
package rxq_pkg;
  localparam int          RXQ_FILT_OVERSAMPLE = 29;
  localparam int          RXQ_QUAL_RUN_BITS   = 5;
  localparam logic [2:0]  RXQ_QUAL_MAX        = 3'h7;
  localparam logic [7:0]  RXQ_SYNC_FIXED_BYTE = 8'h2D;
  localparam logic [2:0]  RXQ_STRENGTH_MAX    = 3'h5;
  localparam int          RXQ_RATE_W          = 16;
  localparam logic [15:0] RXQ_RATE_RESET      = 16'h0010;
  localparam int          RXQ_CNT_W           = 5;
  localparam int          RXQ_LOCK_SLOW_BITS  = 8;
  localparam int          RXQ_LOCK_FAST_BITS  = 2;
  localparam int          RXQ_STS_W           = 9;
  localparam int          RXQ_STS_QUAL_BIT    = 7;
  localparam int          RXQ_STS_STRENGTH_BIT = 8;
  localparam int          RXQ_STS_LOCK_BIT    = 6;

  typedef enum logic [1:0] {
    RXQ_CR_AUTO,
    RXQ_CR_SLOW,
    RXQ_CR_FAST,
    RXQ_CR_RSVD
  } rxq_cr_mode_t;

  typedef enum logic [2:0] {
    RXQ_VD_DEFAULT,
    RXQ_VD_SLOW,
    RXQ_VD_MEDIUM,
    RXQ_VD_FAST,
    RXQ_VD_OFF
  } rxq_vd_mode_t;
endpackage

//--- rtl/rxq_sync2.sv
// Purpose: Two flip-flop synchroniser for asynchronous pin levels
// Assumes: Single clock, synchronous active high reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module rxq_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- rtl/rxq_clock_recovery_unit.sv
// Purpose: Recovers a bit clock from the oversampled data and reports lock
// Assumes: Sample tick at 29 times the bit rate, synchronised data
// Notes:   Slow mode needs a longer run of clean bits before lock
`timescale 1ns/10ps
`default_nettype none
module rxq_clock_recovery_unit
  import rxq_pkg::*;
#(
  parameter int OVS = RXQ_FILT_OVERSAMPLE
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         tick_in,
  input  wire logic         data_in,
  input  wire rxq_cr_mode_t mode_in,
  output logic              bit_stb_out,
  output logic              bit_out,
  output logic              lock_out
);
  localparam logic [RXQ_CNT_W-1:0] PH_LAST = RXQ_CNT_W'(OVS - 1);
  localparam logic [RXQ_CNT_W-1:0] PH_MID  = RXQ_CNT_W'(OVS / 2);
  localparam logic [3:0]           N_SLOW  = 4'(RXQ_LOCK_SLOW_BITS);
  localparam logic [3:0]           N_FAST  = 4'(RXQ_LOCK_FAST_BITS);

  logic [RXQ_CNT_W-1:0] phase_q;
  logic                 prev_q;
  logic [3:0]           good_q;
  logic                 use_fast;
  logic                 edge_seen;
  logic                 early_edge;

  // Automatic mode runs fast until locked, then slow
  always_comb begin
    case (mode_in)
      RXQ_CR_SLOW: use_fast = 1'b0;
      RXQ_CR_FAST: use_fast = 1'b1;
      RXQ_CR_AUTO: use_fast = !lock_out;
      default:     use_fast = 1'b1;
    endcase
  end

  assign edge_seen  = tick_in && (data_in != prev_q);
  assign early_edge = edge_seen && (phase_q > 5'(2)) && (phase_q < PH_LAST - 5'(2));

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_q     <= '0;
      prev_q      <= 1'b0;
      bit_stb_out <= 1'b0;
      bit_out     <= 1'b0;
    end else begin
      bit_stb_out <= 1'b0;
      if (tick_in) begin
        prev_q <= data_in;
        // Fast mode snaps phase on any edge, slow nudges one tick either way
        if (edge_seen && use_fast) begin
          phase_q <= '0;
        end else if (edge_seen && phase_q > PH_MID && phase_q < PH_LAST - 5'(1)) begin
          phase_q <= phase_q + 5'(2);
        end else if (edge_seen && phase_q != '0 && phase_q < PH_MID) begin
          // Late edge: hold one tick so slow mode can pull back as well
          phase_q <= phase_q;
        end else if (phase_q == PH_LAST) begin
          phase_q <= '0;
        end else begin
          phase_q <= phase_q + 5'(1);
        end
        if (phase_q == PH_MID) begin
          bit_stb_out <= 1'b1;
          bit_out     <= data_in;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      good_q   <= '0;
      lock_out <= 1'b0;
    end else if (tick_in) begin
      if (early_edge) begin
        good_q   <= '0;
        lock_out <= 1'b0;
      end else if (phase_q == PH_LAST) begin
        if (good_q != 4'hF) begin
          good_q <= good_q + 4'(1);
        end
        if (good_q + 4'(1) >= (use_fast ? N_FAST : N_SLOW)) begin
          lock_out <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/rxq_rx_data_validity.sv
// Purpose: Receive data qualification: filter clocking, quality, validity, sync, strength
// Assumes: Demodulator output and strength comparator are asynchronous pins
// Notes:   Control fields are plain ports held stable by the host interface
`timescale 1ns/10ps
`default_nettype none
module rxq_rx_data_validity
  import rxq_pkg::*;
#(
  parameter int OVS    = RXQ_FILT_OVERSAMPLE,
  parameter int RATE_W = RXQ_RATE_W
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              demod_data_in,
  input  wire logic              strength_cmp_in,
  input  wire logic              antenna_strong_in,
  input  wire logic              rx_enable_in,
  input  wire logic              tx_mode_in,
  input  wire logic              digital_filter_in,
  input  wire logic              fifo_enable_in,
  input  wire logic              sync_word_mode_in,
  input  wire logic              sync_restart_in,
  input  wire logic [7:0]        sync_programmable_byte_in,
  input  wire logic [RATE_W-1:0] rate_divider_in,
  input  wire logic              rate_prescale_in,
  input  wire rxq_cr_mode_t      recovery_mode_in,
  input  wire rxq_vd_mode_t      valid_mode_in,
  input  wire logic [2:0]        quality_threshold_field_in,
  input  wire logic [2:0]        strength_threshold_field_in,
  output logic                   fifo_bit_valid_out,
  output logic                   fifo_bit_out,
  output logic                   recovered_clock_pin_out,
  output logic                   data_pin_out,
  output logic                   valid_data_flag_out,
  output logic                   quality_indicator_out,
  output logic                   recovery_lock_out,
  output logic                   sync_found_out,
  output logic [RXQ_STS_W-1:0]   status_word_out,
  output logic [2:0]             strength_level_out
);
  import rxq_pkg::*;

  localparam logic [2:0] PRESCALE_LAST = 3'h7;

  logic       data_s;
  logic       strength_s;
  logic       antenna_s;
  logic [RATE_W-1:0] div_q;
  logic [2:0] pre_q;
  logic       tick_q;
  logic       bit_stb;
  logic       bit_val;
  logic       lock;
  logic [4:0] run_len_q;
  logic [4:0] hi_len_q;
  logic [4:0] lo_len_q;
  logic       prev_s_q;
  logic [2:0] good_bits_q;
  logic       good_hi_q;
  logic       good_lo_q;
  logic       qual_q;
  logic       strength_flag;
  logic       vd_q;
  logic [15:0] shift_q;
  logic       synced_q;
  logic       rclk_q;

  function automatic logic sync_hit(input logic [15:0] sr, input logic word_mode, input logic [7:0] lo);
    sync_hit = word_mode ? (sr == {RXQ_SYNC_FIXED_BYTE, lo}) : (sr[7:0] == lo);
  endfunction

  rxq_sync2 #(.W(3)) u_sync (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .async_in ({demod_data_in, strength_cmp_in, antenna_strong_in}),
    .sync_out ({data_s, strength_s, antenna_s})
  );

  // Filter tick generator, one oversample period is the divider plus one clk cycles
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_q  <= '0;
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!rx_enable_in || !digital_filter_in) begin
        div_q <= '0;
        pre_q <= '0;
      end else if (div_q >= rate_divider_in) begin
        div_q <= '0;
        // Prescaler stretches each period eightfold for slow rates
        if (!rate_prescale_in || pre_q == PRESCALE_LAST) begin
          pre_q  <= '0;
          tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 3'(1);
        end
      end else begin
        div_q <= div_q + RATE_W'(1);
      end
    end
  end

  rxq_clock_recovery_unit #(.OVS(OVS)) u_cru (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .tick_in     (tick_q),
    .data_in     (data_s),
    .mode_in     (recovery_mode_in),
    .bit_stb_out (bit_stb),
    .bit_out     (bit_val),
    .lock_out    (lock)
  );

  // Quality measure: each half-bit run length compared with three times the threshold
  always_ff @(posedge clk_in) begin
    if (srst_in || !rx_enable_in) begin
      run_len_q <= '0;
      hi_len_q  <= '0;
      lo_len_q  <= '0;
      prev_s_q  <= 1'b0;
      good_hi_q <= 1'b0;
      good_lo_q <= 1'b0;
    end else if (tick_q) begin
      prev_s_q <= data_s;
      if (data_s != prev_s_q) begin
        run_len_q <= 5'(1);
        if (prev_s_q) begin
          hi_len_q  <= run_len_q;
          good_hi_q <= run_len_q >= 5'(quality_threshold_field_in) * 5'(3);
        end else begin
          lo_len_q  <= run_len_q;
          good_lo_q <= run_len_q >= 5'(quality_threshold_field_in) * 5'(3);
        end
      end else if (run_len_q != 5'h1F) begin
        run_len_q <= run_len_q + 5'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !rx_enable_in) begin
      good_bits_q <= '0;
      qual_q      <= 1'b0;
    end else if (bit_stb) begin
      if (good_hi_q && good_lo_q && quality_threshold_field_in <= RXQ_QUAL_MAX) begin
        if (good_bits_q != 3'(RXQ_QUAL_RUN_BITS)) begin
          good_bits_q <= good_bits_q + 3'(1);
        end
        qual_q <= good_bits_q + 3'(1) >= 3'(RXQ_QUAL_RUN_BITS);
      end else begin
        good_bits_q <= '0;
        qual_q      <= 1'b0;
      end
    end
  end

  assign strength_flag = strength_s && rx_enable_in && (strength_threshold_field_in <= RXQ_STRENGTH_MAX);

  // Valid data flag by response mode
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      vd_q <= 1'b1;
    end else begin
      case (valid_mode_in)
        RXQ_VD_DEFAULT: vd_q <= 1'b1;
        RXQ_VD_SLOW: begin
          if (strength_flag && qual_q && lock) begin
            vd_q <= 1'b1;
          end else if (!strength_flag && !qual_q && !lock) begin
            vd_q <= 1'b0;
          end
        end
        RXQ_VD_MEDIUM: vd_q <= lock && (strength_flag || qual_q);
        RXQ_VD_FAST:   vd_q <= qual_q;
        RXQ_VD_OFF:    vd_q <= 1'b1;
        default:       vd_q <= 1'b1;
      endcase
    end
  end

  // Sync search then bit delivery to the FIFO
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      shift_q  <= '0;
      synced_q <= 1'b0;
    end else if (sync_restart_in || !rx_enable_in || !digital_filter_in) begin
      shift_q  <= '0;
      synced_q <= 1'b0;
    end else if (bit_stb && !synced_q) begin
      shift_q <= {shift_q[14:0], bit_val};
      if (sync_hit({shift_q[14:0], bit_val}, sync_word_mode_in, sync_programmable_byte_in)) begin
        synced_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fifo_bit_valid_out <= 1'b0;
      fifo_bit_out       <= 1'b0;
      rclk_q             <= 1'b0;
      recovered_clock_pin_out <= 1'b0;
    end else begin
      fifo_bit_valid_out <= bit_stb && synced_q && fifo_enable_in && digital_filter_in;
      fifo_bit_out       <= bit_val;
      if (bit_stb) begin
        rclk_q <= 1'b1;
      end else if (tick_q) begin
        rclk_q <= 1'b0;
      end
      recovered_clock_pin_out <= !fifo_enable_in && digital_filter_in && rclk_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_pin_out          <= 1'b0;
      valid_data_flag_out   <= 1'b1;
      quality_indicator_out <= 1'b0;
      recovery_lock_out     <= 1'b0;
      sync_found_out        <= 1'b0;
      status_word_out       <= '0;
      strength_level_out    <= '0;
    end else begin
      // Raw comparator data when qualification is off
      if (valid_mode_in == RXQ_VD_OFF) begin
        data_pin_out <= data_s;
      end else if (digital_filter_in) begin
        data_pin_out <= bit_val && vd_q;
      end else begin
        data_pin_out <= data_s && vd_q;
      end
      valid_data_flag_out   <= vd_q;
      quality_indicator_out <= qual_q;
      recovery_lock_out     <= lock;
      sync_found_out        <= synced_q;
      strength_level_out    <= strength_threshold_field_in;
      status_word_out       <= '0;
      status_word_out[RXQ_STS_STRENGTH_BIT] <= tx_mode_in ? antenna_s : strength_flag;
      status_word_out[RXQ_STS_QUAL_BIT]     <= qual_q && strength_flag;
      status_word_out[RXQ_STS_LOCK_BIT]     <= lock;
    end
  end
endmodule
`default_nettype wire

//--- dv/rxq_rx_data_validity_assertions.sv
// Purpose: Port-level checks for receive data qualification
// Assumes: One clock, synchronous reset
// Notes:   Windows allow for the pin synchronisers
`timescale 1ns/10ps
`default_nettype none
module rxq_rx_data_validity_assertions
  import rxq_pkg::*;
(
  input wire logic                 clk_in,
  input wire logic                 srst_in,
  input wire logic                 demod_data_in,
  input wire logic                 rx_enable_in,
  input wire logic                 tx_mode_in,
  input wire logic                 digital_filter_in,
  input wire rxq_vd_mode_t         valid_mode_in,
  input wire logic [2:0]           strength_threshold_field_in,
  input wire logic                 fifo_bit_valid_out,
  input wire logic                 recovered_clock_pin_out,
  input wire logic                 data_pin_out,
  input wire logic                 valid_data_flag_out,
  input wire logic                 quality_indicator_out,
  input wire logic                 recovery_lock_out,
  input wire logic                 sync_found_out,
  input wire logic [RXQ_STS_W-1:0] status_word_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  dflt_high_a: assert property (
    valid_mode_in == RXQ_VD_DEFAULT |-> ##2 valid_data_flag_out)
    else $error("flag low in default mode");
  fast_track_a: assert property (
    (valid_mode_in == RXQ_VD_FAST && $stable(quality_indicator_out))[*3]
    |-> valid_data_flag_out == quality_indicator_out) else $error("fast flag off quality");
  slow_hold_a: assert property (
    (valid_mode_in == RXQ_VD_SLOW)[*3] ##0 quality_indicator_out && $past(quality_indicator_out)
    && $past(valid_data_flag_out) |-> valid_data_flag_out) else $error("slow flag dropped");
  med_lock_a: assert property (
    (valid_mode_in == RXQ_VD_MEDIUM)[*3] ##0 valid_data_flag_out
    |-> recovery_lock_out || $past(recovery_lock_out)) else $error("medium flag without lock");
  off_raw_a: assert property (
    (valid_mode_in == RXQ_VD_OFF && demod_data_in)[*5] |-> data_pin_out)
    else $error("raw data not passed");
  analog_quiet_a: assert property (
    (!digital_filter_in)[*4] |-> !recovered_clock_pin_out && !fifo_bit_valid_out)
    else $error("clock or fifo in analog mode");
  fifo_sync_a: assert property (
    fifo_bit_valid_out |-> sync_found_out || $past(sync_found_out))
    else $error("fifo write before sync");
  rx_off_a: assert property (
    (!rx_enable_in)[*3] |-> !quality_indicator_out && !sync_found_out)
    else $error("quality with receiver off");
  code_rsvd_a: assert property (
    (!tx_mode_in && strength_threshold_field_in > RXQ_STRENGTH_MAX)[*4]
    |-> !status_word_out[RXQ_STS_STRENGTH_BIT] && !status_word_out[RXQ_STS_QUAL_BIT])
    else $error("reserved code set strength");
endmodule
bind rxq_rx_data_validity rxq_rx_data_validity_assertions u_rxq_rx_data_validity_assertions (
  .clk_in, .srst_in, .demod_data_in, .rx_enable_in, .tx_mode_in, .digital_filter_in, .valid_mode_in,
  .strength_threshold_field_in, .fifo_bit_valid_out, .recovered_clock_pin_out, .data_pin_out,
  .valid_data_flag_out, .quality_indicator_out, .recovery_lock_out, .sync_found_out, .status_word_out);
`default_nettype wire

//--- dv/rxq_demod_model.sv
// Purpose: Demodulator stand-in feeding the receive path
// Assumes: Bit period given in system clocks
// Notes:   Between frames it sends an alternating preamble
`timescale 1ns/10ps
`default_nettype none
module rxq_demod_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] period_in,
  input  wire logic        send_in,
  input  wire logic [31:0] frame_in,
  output logic             data_out,
  output logic             busy_out
);
  int          cnt_q = 0;
  int          left_q = 0;
  logic [31:0] frame_q = 32'h0000_0000;
  initial data_out = 1'b0;
  assign busy_out = (left_q != 0);
  always @(posedge clk_in) begin
    if (cnt_q >= int'(period_in) - 1) begin
      cnt_q <= 0;
      if (left_q != 0) begin
        data_out <= frame_q[left_q-1];
        left_q   <= left_q - 1;
      end else if (send_in) begin
        data_out <= frame_in[31];
        frame_q  <= frame_in;
        left_q   <= 31;
      end else begin
        data_out <= !data_out;
      end
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/rxq_rx_data_validity_tb.sv
// Purpose: Self-checking bench for receive data qualification
// Assumes: Divider 0 gives a 29 clock bit
// Notes:   Frames carry a sync word then C3h
`timescale 1ns/10ps
`default_nettype none
module rxq_rx_data_validity_tb;
  import rxq_pkg::*;
  logic                 clk_in, demod_data_in, busy, send = 1'b0, srst_in = 1'b1;
  logic                 strength_cmp_in = 1'b1, antenna_strong_in = 1'b0, rx_enable_in = 1'b1;
  logic                 tx_mode_in = 1'b0, digital_filter_in = 1'b1, fifo_enable_in = 1'b1;
  logic                 sync_word_mode_in = 1'b1, sync_restart_in = 1'b0, rate_prescale_in = 1'b0;
  logic [7:0]           sync_programmable_byte_in = 8'hA5;
  logic [15:0]          rate_divider_in = 16'h0000, period = 16'h001D;
  logic [31:0]          frame = 32'h0000_0000;
  rxq_cr_mode_t         recovery_mode_in = RXQ_CR_AUTO;
  rxq_vd_mode_t         valid_mode_in = RXQ_VD_DEFAULT;
  logic [2:0]           quality_threshold_field_in = 3'h5, strength_threshold_field_in = 3'h0;
  logic [2:0]           strength_level_out;
  logic                 fifo_bit_valid_out, fifo_bit_out, recovered_clock_pin_out, data_pin_out;
  logic                 valid_data_flag_out, quality_indicator_out, recovery_lock_out, sync_found_out;
  logic [RXQ_STS_W-1:0] status_word_out;
  int                   miscompares = 0;
  int                   tests_run = 0;

  rxq_demod_model u_rxq_demod_model (.clk_in, .period_in(period), .send_in(send), .frame_in(frame),
    .data_out(demod_data_in), .busy_out(busy));
  rxq_rx_data_validity u_rxq_rx_data_validity (.clk_in, .srst_in, .demod_data_in, .strength_cmp_in,
    .antenna_strong_in, .rx_enable_in, .tx_mode_in, .digital_filter_in, .fifo_enable_in,
    .sync_word_mode_in, .sync_restart_in, .sync_programmable_byte_in, .rate_divider_in,
    .rate_prescale_in, .recovery_mode_in, .valid_mode_in, .quality_threshold_field_in,
    .strength_threshold_field_in, .fifo_bit_valid_out, .fifo_bit_out, .recovered_clock_pin_out,
    .data_pin_out, .valid_data_flag_out, .quality_indicator_out, .recovery_lock_out,
    .sync_found_out, .status_word_out, .strength_level_out);

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = !clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wait_for(ref logic sig, input logic lvl, input int bound, output int n);
    n = 0;
    while (sig !== lvl) begin
      @(posedge clk_in);
      n++;
      if (n > bound) begin
        check(sig, lvl);
        end_sim();
      end
    end
  endtask
  task automatic do_reset();
    srst_in <= 1'b1;
    clks(3);
    srst_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Frame starts at a bit boundary; sync search is cleared first
  task automatic send_frame(input logic [7:0] hi);
    int n;
    wait_for(busy, 1'b0, 1500, n);
    sync_restart_in <= 1'b1;
    @(posedge clk_in);
    sync_restart_in <= 1'b0;
    frame <= {hi, 8'hA5, 8'hC3, 8'h3C};
    send <= 1'b1;
    wait_for(busy, 1'b1, 300, n);
    send <= 1'b0;
  endtask
  task automatic get_byte(output logic [7:0] b);
    int n;
    for (int i = 0; i < 8; i++) begin
      wait_for(fifo_bit_valid_out, 1'b1, 1500, n);
      b = {b[6:0], fifo_bit_out};
      @(posedge clk_in);
    end
  endtask
  task automatic count_rclk(input int cyc, output int c);
    logic prev;
    c = 0;
    prev = recovered_clock_pin_out;
    repeat (cyc) begin
      @(posedge clk_in);
      if (recovered_clock_pin_out && !prev) c++;
      prev = recovered_clock_pin_out;
    end
  endtask
  task automatic set_mode(input rxq_vd_mode_t m, input logic exp);
    valid_mode_in <= m;
    clks(8);
    check(valid_data_flag_out, exp);
  endtask

  initial begin
    int           t[3];
    int           n;
    logic [7:0]   b;
    int           per[3] = '{29, 58, 232};
    rxq_vd_mode_t ma[5] = '{RXQ_VD_DEFAULT, RXQ_VD_MEDIUM, RXQ_VD_FAST, RXQ_VD_OFF, RXQ_VD_SLOW};
    clks(2);
    check({valid_data_flag_out, quality_indicator_out, recovery_lock_out, sync_found_out,
           fifo_bit_valid_out, status_word_out}, {1'b1, 13'h0000});
    srst_in <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      recovery_mode_in <= rxq_cr_mode_t'(m);
      do_reset();
      wait_for(recovery_lock_out, 1'b1, 1500, t[m]);
    end
    check(t[2] < t[1], 1'b1);
    check(t[0] < t[1], 1'b1);
    $display("lock test done");
    recovery_mode_in <= RXQ_CR_AUTO;
    do_reset();
    wait_for(quality_indicator_out, 1'b1, 1500, n);
    check(n >= (RXQ_QUAL_RUN_BITS - 1) * RXQ_FILT_OVERSAMPLE, 1'b1);
    send_frame(8'h2C);
    wait_for(busy, 1'b0, 1500, n);
    clks(60);
    check(sync_found_out, 1'b0);
    sync_word_mode_in <= 1'b0;
    send_frame(8'h2C);
    get_byte(b);
    check(b, 8'hC3);
    sync_word_mode_in <= 1'b1;
    send_frame(RXQ_SYNC_FIXED_BYTE);
    get_byte(b);
    check(b, 8'hC3);
    $display("sync test done");
    fifo_enable_in <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      period <= 16'(per[k]);
      rate_divider_in <= 16'(k % 2);
      rate_prescale_in <= (k == 2);
      clks(per[k] * 12);
      count_rclk(per[k] * 10, n);
      check(n >= 9 && n <= 11, 1'b1);
    end
    period <= 16'h001D;
    rate_divider_in <= 16'h0000;
    rate_prescale_in <= 1'b0;
    digital_filter_in <= 1'b0;
    clks(20);
    count_rclk(300, n);
    check(n, 0);
    digital_filter_in <= 1'b1;
    $display("clock test done");
    do_reset();
    wait_for(quality_indicator_out, 1'b1, 1500, n);
    for (int c = 0; c < 8; c++) begin
      strength_threshold_field_in <= 3'(c);
      clks(6);
      check(status_word_out[RXQ_STS_STRENGTH_BIT], c <= int'(RXQ_STRENGTH_MAX));
      check(status_word_out[RXQ_STS_QUAL_BIT], c <= int'(RXQ_STRENGTH_MAX));
      check(strength_level_out, c);
    end
    strength_threshold_field_in <= 3'h0;
    tx_mode_in <= 1'b1;
    antenna_strong_in <= 1'b1;
    clks(8);
    check(status_word_out[RXQ_STS_STRENGTH_BIT], 1'b1);
    antenna_strong_in <= 1'b0;
    clks(8);
    check(status_word_out[RXQ_STS_STRENGTH_BIT], 1'b0);
    tx_mode_in <= 1'b0;
    $display("strength test done");
    wait_for(recovery_lock_out, 1'b1, 1500, n);
    foreach (ma[i]) set_mode(ma[i], 1'b1);
    strength_cmp_in <= 1'b0;
    set_mode(RXQ_VD_SLOW, 1'b1);
    set_mode(RXQ_VD_MEDIUM, 1'b1);
    rx_enable_in <= 1'b0;
    set_mode(RXQ_VD_MEDIUM, 1'b0);
    check({quality_indicator_out, sync_found_out}, 2'h0);
    set_mode(RXQ_VD_FAST, 1'b0);
    set_mode(RXQ_VD_DEFAULT, 1'b1);
    $display("valid flag test done");
    end_sim();
  end
endmodule
`default_nettype wire
